//--- design/ldu_diag.sv
// Purpose: Link diagnostics unit of one port: linked cable status, quality monitor, variance sum, cable test.
// Assumes: Register accesses arrive from the management frame decoder on the device clock; DSP values are synchronous.
// Notes: Read data is registered and valid the cycle after the read strobe.
`include "ldu_cfg.svh"
module ldu_diag
	import ldu_pkg::*;
#(
	parameter int MS_CYCLES = `LDU_MS_CYCLES
)
(
	input  wire logic        clk,
	input  wire logic        rst_n,
	input  wire logic [4:0]  reg_addr,
	input  wire logic [15:0] reg_wdata,
	input  wire logic        reg_wr,
	input  wire logic        reg_rd,
	output logic      [15:0] reg_rdata,
	input  wire logic        link_valid,
	input  wire logic        speed_100,
	input  wire logic        an_mode,
	input  wire logic        pol_inverted,
	input  wire logic        mdix_active,
	input  wire ldu_byte_t   cable_length_raw,
	input  wire ldu_byte_t   freq_offset_raw,
	input  wire ldu_byte_t   frequency_control_value,
	input  wire ldu_byte_t   equalizer_coefficient,
	input  wire ldu_byte_t   adaptive_gain_value,
	input  wire ldu_byte_t   baseline_wander_value,
	input  wire logic [15:0] error_square,
	output logic             int_n,
	output logic             test_enable,
	output logic             tx_on_rx_pair,
	output logic             rx_on_rx_pair,
	output logic             drive_100,
	output logic             drive_pos,
	output logic             drive_neg,
	output logic      [2:0]  width_code,
	output logic             monitor_start
);
	// ----------------------------------------------------------------
	// Helpers
	// ----------------------------------------------------------------

	// Strict comparison, signed for all parameters except gain.
	function automatic logic ldu_exceeds(input ldu_byte_t a, input ldu_byte_t b, input logic sgn);
		ldu_exceeds = sgn ? ($signed(a) > $signed(b)) : (a > b);
	endfunction : ldu_exceeds

	// ----------------------------------------------------------------
	// Register state
	// ----------------------------------------------------------------
	logic [2:0]  page;
	logic        int_oe;
	logic        inten;
	logic [7:0]  int_mask;
	logic        lq_pending;
	logic        freq_sel;
	logic [15:0] test_ctrl;
	logic [1:0]  var_timer;
	logic        var_ready;
	logic        lqm_en;
	logic [2:0]  lq_sel;
	logic        lq_hi;
	logic        lq_sample_mode;
	ldu_byte_t   lq_sample;
	logic [9:0]  lq_flags;
	logic [31:0] var_acc;
	logic [31:0] var_sum;
	logic [15:0] var_hi_hold;
	logic        var_hi_next;
	logic [15:0] ms_cnt;
	logic [2:0]  ms_num;
	logic [15:0] next_rdata;
	logic        diag_page;
	logic        wr_hit_lqd;
	logic        rd_lqm;
	logic        rd_var;
	logic        rd_interrupt_status_mask_reg;
	logic        cmp_en;
	logic        link_100;
	logic        pol_valid;
	logic        pg_busy;
	logic        test_go;
	logic [9:0]  set_flags;
	logic [79:0] thr_flat;
	ldu_byte_t   thr_rd;
	ldu_byte_t   par [5];

	// Decode of the page 2 window; shared addresses fall through to page 0 otherwise.
	assign diag_page = (page == `LDU_DIAG_PAGE);
	assign link_100 = link_valid && speed_100;
	assign pol_valid = !speed_100 || an_mode;
	assign cmp_en = lqm_en && link_100;
	assign wr_hit_lqd = reg_wr && diag_page && reg_addr == `LDU_LQD_ADDR;
	assign rd_lqm = reg_rd && diag_page && reg_addr == `LDU_LQM_ADDR;
	assign rd_var = reg_rd && diag_page && reg_addr == `LDU_VAR_DATA_ADDR;
	assign rd_interrupt_status_mask_reg = reg_rd && reg_addr == `LDU_INT_STAT_ADDR;
	assign test_go = reg_wr && diag_page && reg_addr == `LDU_TEST_ADDR &&
		reg_wdata[`LDU_TST_GO_BIT] && reg_wdata[`LDU_TST_EN_BIT];

	// Monitored values in select order: equalizer, gain, baseline wander, offset, control.
	assign par[0] = equalizer_coefficient;
	assign par[1] = adaptive_gain_value;
	assign par[2] = baseline_wander_value;
	assign par[3] = freq_offset_raw;
	assign par[4] = frequency_control_value;

	// ----------------------------------------------------------------
	// Control registers
	// ----------------------------------------------------------------

	// Page, interrupt control and mask.
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			page <= 3'd0;
			int_oe <= 1'b0;
			inten <= 1'b0;
			int_mask <= 8'h00;
		end else if (reg_wr) begin
			if (reg_addr == `LDU_PAGE_ADDR) begin
				page <= reg_wdata[2:0];
			end
			if (reg_addr == `LDU_INT_CTRL_ADDR) begin
				int_oe <= reg_wdata[`LDU_INT_OE_BIT];
				inten <= reg_wdata[`LDU_INTEN_BIT];
			end
			if (reg_addr == `LDU_INT_STAT_ADDR) begin
				int_mask <= reg_wdata[7:0];
			end
		end
	end

	// Page 2 configuration: offset source, cable test, variance interval, monitor enable.
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			freq_sel <= 1'b0;
			test_ctrl <= 16'h0000;
			var_timer <= 2'd0;
			lqm_en <= 1'b0;
		end else if (reg_wr && diag_page) begin
			if (reg_addr == `LDU_FREQ_ADDR) begin
				freq_sel <= reg_wdata[`LDU_FREQ_SEL_BIT];
			end
			if (reg_addr == `LDU_TEST_ADDR) begin
				test_ctrl <= reg_wdata & 16'hF7FF; // The send bit self-clears; busy reads in its place.
			end
			if (reg_addr == `LDU_VAR_CTRL_ADDR) begin
				var_timer <= reg_wdata[2:1];
			end
			if (reg_addr == `LDU_LQM_ADDR) begin
				lqm_en <= reg_wdata[`LDU_LQM_EN_BIT];
			end
		end
	end

	// Indirect data register: select, side, and an optional live sample.
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			lq_sel <= 3'd0;
			lq_hi <= 1'b0;
			lq_sample_mode <= 1'b0;
			lq_sample <= 8'h00;
		end else if (wr_hit_lqd) begin
			lq_sel <= reg_wdata[11:9];
			lq_hi <= reg_wdata[`LDU_LQD_HI_BIT];
			lq_sample_mode <= reg_wdata[`LDU_LQD_SMP_BIT];
			if (reg_wdata[`LDU_LQD_SMP_BIT]) begin
				lq_sample <= (reg_wdata[11:9] < 3'd5) ? par[reg_wdata[11:9]] : 8'h00;
			end
		end
	end

	ldu_thr_mem u_thr (
		.clk      (clk),
		.rst_n    (rst_n),
		.wr_en    (wr_hit_lqd && reg_wdata[`LDU_LQD_WR_BIT] && !reg_wdata[`LDU_LQD_SMP_BIT]),
		.wr_addr  ({reg_wdata[11:9], reg_wdata[`LDU_LQD_HI_BIT]}),
		.wr_data  (reg_wdata[7:0]),
		.rd_addr  ({lq_sel, lq_hi}),
		.rd_data  (thr_rd),
		.thr_flat (thr_flat)
	);

	// ----------------------------------------------------------------
	// Link quality monitor
	// ----------------------------------------------------------------

	// Two comparators per value; a window exit sets the low or high flag.
	for (genvar p = 0; p < 5; p++) begin : g_cmp
		localparam logic SGN = (p != 1);
		assign set_flags[2*p] = cmp_en && ldu_exceeds(thr_flat[(2*p)*8 +: 8], par[p], SGN);
		assign set_flags[2*p+1] = cmp_en && ldu_exceeds(par[p], thr_flat[(2*p+1)*8 +: 8], SGN);
	end

	// Flags stick until the status is read; a new exit in the read cycle survives.
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			lq_flags <= 10'h000;
		end else begin
			lq_flags <= (rd_lqm ? 10'h000 : lq_flags) | set_flags;
		end
	end

	// Pending bit and pin; the pin only asserts when both enables and the mask allow it.
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			lq_pending <= 1'b0;
			int_n <= 1'b1;
		end else begin
			lq_pending <= (rd_interrupt_status_mask_reg ? 1'b0 : lq_pending) | ((|set_flags) && int_mask[`LDU_LQ_MASK_BIT]);
			int_n <= !(int_oe && inten && lq_pending);
		end
	end

	// ----------------------------------------------------------------
	// Variance sum
	// ----------------------------------------------------------------

	// Millisecond tick and interval count; the sum restarts whenever the 100 Mb link drops.
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			ms_cnt <= 16'd0;
			ms_num <= 3'd0;
			var_acc <= 32'd0;
			var_sum <= 32'd0;
			var_ready <= 1'b0;
		end else begin
			if (!link_100) begin
				ms_cnt <= 16'd0;
				ms_num <= 3'd0;
				var_acc <= 32'd0;
			end else if (ms_cnt == 16'(MS_CYCLES - 1)) begin
				ms_cnt <= 16'd0;
				if (ms_num == {var_timer, 1'b1}) begin
					ms_num <= 3'd0;
					var_sum <= var_acc + 32'(error_square);
					var_acc <= 32'd0;
				end else begin
					ms_num <= ms_num + 3'd1;
					var_acc <= var_acc + 32'(error_square);
				end
			end else begin
				ms_cnt <= ms_cnt + 16'd1;
				var_acc <= var_acc + 32'(error_square);
			end
			var_ready <= (rd_var && var_hi_next ? 1'b0 : var_ready) |
				(link_100 && ms_cnt == 16'(MS_CYCLES - 1) && ms_num == {var_timer, 1'b1});
		end
	end

	// First read returns the low half and freezes the high half for the second read.
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			var_hi_next <= 1'b0;
			var_hi_hold <= 16'h0000;
		end else if (rd_var) begin
			var_hi_next <= !var_hi_next;
			if (!var_hi_next) begin
				var_hi_hold <= var_sum[31:16];
			end
		end
	end

	// ----------------------------------------------------------------
	// Cable test pulse generator
	// ----------------------------------------------------------------
	assign test_enable = test_ctrl[`LDU_TST_EN_BIT];
	assign drive_100 = test_ctrl[`LDU_TST_100_BIT];
	assign tx_on_rx_pair = test_ctrl[`LDU_TST_TXP_BIT];
	assign rx_on_rx_pair = test_ctrl[`LDU_TST_RXP_BIT];

	ldu_pulse_gen u_pulse (
		.clk           (clk),
		.rst_n         (rst_n),
		.send          (test_go),
		.mode_100      (reg_wdata[`LDU_TST_100_BIT]),
		.wide_10       (reg_wdata[`LDU_TST_WIDE_BIT]),
		.width         (reg_wdata[10:8]),
		.drive_pos     (drive_pos),
		.drive_neg     (drive_neg),
		.width_code    (width_code),
		.monitor_start (monitor_start),
		.busy          (pg_busy)
	);

	// ----------------------------------------------------------------
	// Read path
	// ----------------------------------------------------------------

	// Read mux; unmapped or off-page addresses read zero, except 0x1A, which shows the 10 Mb polarity bit off page 2.
	always_comb begin
		next_rdata = 16'h0000;
		unique case (reg_addr)
			`LDU_PHY_STATUS_ADDR: begin
				next_rdata[`LDU_LINK_BIT] = link_valid;
				next_rdata[`LDU_SPEED10_BIT] = !speed_100;
				next_rdata[`LDU_POL_BIT] = pol_inverted && pol_valid;
				next_rdata[`LDU_MDIX_BIT] = mdix_active;
			end
			`LDU_INT_CTRL_ADDR: next_rdata = {14'h0, inten, int_oe};
			`LDU_INT_STAT_ADDR: next_rdata = {lq_pending, 7'h00, int_mask};
			`LDU_PAGE_ADDR: next_rdata = {13'h0, page};
			`LDU_LEN_ADDR: next_rdata = (diag_page && link_100) ? {8'h00, cable_length_raw} : 16'h0000;
			`LDU_FREQ_ADDR: begin
				if (diag_page && link_100) begin
					next_rdata = {7'h00, freq_sel, freq_sel ? frequency_control_value : freq_offset_raw};
				end
			end
			`LDU_TEST_ADDR: next_rdata = diag_page ? (test_ctrl | {4'h0, pg_busy, 11'h000}) : 16'h0000;
			`LDU_VAR_CTRL_ADDR: begin
				if (diag_page) begin
					next_rdata = {var_ready, 12'h000, var_timer, 1'b0};
				end else begin
					next_rdata[`LDU_TEN_POL_BIT] = pol_inverted && pol_valid;
				end
			end
			`LDU_VAR_DATA_ADDR: begin
				if (diag_page) begin
					next_rdata = var_hi_next ? var_hi_hold : var_sum[15:0];
				end
			end
			`LDU_LQM_ADDR: next_rdata = diag_page ? {lqm_en, 5'h00, lq_flags} : 16'h0000;
			`LDU_LQD_ADDR: begin
				if (diag_page) begin
					next_rdata = {2'b00, lq_sample_mode, 1'b0, lq_sel, lq_hi, lq_sample_mode ? lq_sample : thr_rd};
				end
			end
			default: next_rdata = 16'h0000;
		endcase
	end

	// Read data register, loaded on the read strobe only.
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			reg_rdata <= 16'h0000;
		end else if (reg_rd) begin
			reg_rdata <= next_rdata;
		end
	end

	// ----------------------------------------------------------------
	// Checks
	// ----------------------------------------------------------------
	chk_pol_gate: assert property (@(posedge clk) disable iff (!rst_n)
		(reg_rd && reg_addr == `LDU_PHY_STATUS_ADDR && speed_100 && !an_mode) |=> !reg_rdata[`LDU_POL_BIT])
		else $error("Polarity reported in forced 100 Mb mode.");
	chk_mdix_bit: assert property (@(posedge clk) disable iff (!rst_n)
		(reg_rd && reg_addr == `LDU_PHY_STATUS_ADDR) |=> reg_rdata[`LDU_MDIX_BIT] == $past(mdix_active))
		else $error("Crossover bit does not follow the pair state.");
	chk_len_gate: assert property (@(posedge clk) disable iff (!rst_n)
		(reg_rd && reg_addr == `LDU_LEN_ADDR && !link_100) |=> reg_rdata == 16'h0000)
		else $error("Cable length shown without a 100 Mb link.");
	chk_var_halves: assert property (@(posedge clk) disable iff (!rst_n)
		(rd_var && !var_hi_next) |=> (reg_rdata == $past(var_sum[15:0]) && var_hi_hold == $past(var_sum[31:16])))
		else $error("Variance low half or frozen high half wrong.");
	chk_no_equal: assert property (@(posedge clk) disable iff (!rst_n)
		(adaptive_gain_value == thr_flat[31:24]) |-> !set_flags[3])
		else $error("Gain warning raised at equality.");
	chk_flag_sticky: assert property (@(posedge clk) disable iff (!rst_n)
		(lq_flags != 10'h000 && !rd_lqm) |=> ((lq_flags & $past(lq_flags)) == $past(lq_flags)))
		else $error("Warning flag dropped without a status read.");
	chk_cmp_off: assert property (@(posedge clk) disable iff (!rst_n)
		!cmp_en |-> set_flags == 10'h000)
		else $error("Comparison ran while monitor disabled or link down.");
	chk_int_gate: assert property (@(posedge clk) disable iff (!rst_n)
		!inten |=> int_n)
		else $error("Interrupt pin asserted while interrupts disabled.");
	chk_int_rise: assert property (@(posedge clk) disable iff (!rst_n)
		(int_oe && inten && lq_pending) |=> !int_n)
		else $error("Enabled pending warning did not assert the pin.");
endmodule : ldu_diag

//--- design/ldu_cfg.svh
// Purpose: Constants of the link diagnostics unit: register offsets, fields, reset values, timing.
// Assumes: 25 MHz device clock; five-bit register addresses delivered by the management frame decoder.
// Notes: Included by every design file of the unit except the package.
`ifndef LDU_CFG_SVH
`define LDU_CFG_SVH

// ----------------------------------------------------------------
// Register offsets
// ----------------------------------------------------------------
`define LDU_PHY_STATUS_ADDR  5'h10
`define LDU_INT_CTRL_ADDR    5'h11
`define LDU_INT_STAT_ADDR    5'h12
`define LDU_PAGE_ADDR        5'h13
`define LDU_LEN_ADDR         5'h14
`define LDU_FREQ_ADDR        5'h15
`define LDU_TEST_ADDR        5'h16
`define LDU_VAR_CTRL_ADDR    5'h1A
`define LDU_VAR_DATA_ADDR    5'h1B
`define LDU_LQM_ADDR         5'h1D
`define LDU_LQD_ADDR         5'h1E
`define LDU_DIAG_PAGE        3'h2

// ----------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------
`define LDU_LINK_BIT    0
`define LDU_SPEED10_BIT 1
`define LDU_POL_BIT     12
`define LDU_MDIX_BIT    14
`define LDU_TEN_POL_BIT 4
`define LDU_INT_OE_BIT  0
`define LDU_INTEN_BIT   1
`define LDU_LQ_MASK_BIT 7
`define LDU_LQ_STAT_BIT 15
`define LDU_FREQ_SEL_BIT 8
`define LDU_VAR_RDY_BIT 15
`define LDU_LQM_EN_BIT  15
`define LDU_LQD_SMP_BIT 13
`define LDU_LQD_WR_BIT  12
`define LDU_LQD_HI_BIT  8
`define LDU_TST_EN_BIT  15
`define LDU_TST_100_BIT 14
`define LDU_TST_TXP_BIT 13
`define LDU_TST_RXP_BIT 12
`define LDU_TST_GO_BIT  11
`define LDU_TST_WIDE_BIT 6

// ----------------------------------------------------------------
// Reset values and timing
// ----------------------------------------------------------------
`define LDU_SMAX 8'h7F
`define LDU_SMIN 8'h80
`define LDU_UMAX 8'hFF
`define LDU_UMIN 8'h00
`define LDU_CLK_MHZ 25
`define LDU_MS_NS 1000000
`define LDU_MS_CYCLES ((`LDU_MS_NS * `LDU_CLK_MHZ) / 1000)
`define LDU_SHORT_NS 50
`define LDU_LONG_NS 100
`define LDU_SHORT_CYC ((`LDU_SHORT_NS * `LDU_CLK_MHZ + 999) / 1000)
`define LDU_LONG_CYC ((`LDU_LONG_NS * `LDU_CLK_MHZ + 999) / 1000)

`endif

//--- design/ldu_pkg.sv
// Purpose: Types shared by the link diagnostics unit.
// Assumes: Nothing beyond the configuration header.
// Notes: Pulse generator states are Gray coded along idle, fire, done.
package ldu_pkg;
	typedef logic [7:0] ldu_byte_t;
	typedef enum logic [1:0] {
		LDU_PG_IDLE = 2'b00,
		LDU_PG_FIRE = 2'b01,
		LDU_PG_DONE = 2'b11
	} ldu_pulse_state_t;
endpackage : ldu_pkg

//--- design/ldu_thr_mem.sv
// Purpose: Threshold store of the link quality monitor, ten bytes indexed by parameter and side.
// Assumes: Index is parameter times two plus one for the high side.
// Notes: All entries are visible at once for the comparators; the read port is registered.
`include "ldu_cfg.svh"
module ldu_thr_mem
	import ldu_pkg::*;
(
	input  wire logic        clk,
	input  wire logic        rst_n,
	input  wire logic        wr_en,
	input  wire logic [3:0]  wr_addr,
	input  wire ldu_byte_t   wr_data,
	input  wire logic [3:0]  rd_addr,
	output ldu_byte_t        rd_data,
	output logic      [79:0] thr_flat
);
	logic [79:0] reset_flat;

	// Each entry resets to its range limit, so no comparison fires until software programs it.
	for (genvar i = 0; i < 10; i++) begin : g_entry
		localparam ldu_byte_t RST = (i % 2 == 1) ? ((i / 2 == 1) ? `LDU_UMAX : `LDU_SMAX) :
			((i / 2 == 1) ? `LDU_UMIN : `LDU_SMIN);
		assign reset_flat[i*8 +: 8] = RST;
		always_ff @(posedge clk or negedge rst_n) begin
			if (!rst_n) begin
				thr_flat[i*8 +: 8] <= RST;
			end else if (wr_en && wr_addr == 4'(i)) begin
				thr_flat[i*8 +: 8] <= wr_data;
			end
		end
	end

	// Registered read; indices past the last entry read as zero.
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			rd_data <= 8'h00;
		end else begin
			rd_data <= (rd_addr < 4'hA) ? thr_flat[rd_addr*8 +: 8] : 8'h00;
		end
	end

	chk_thr_reset: assert property (@(posedge clk) $rose(rst_n) |-> thr_flat == reset_flat)
		else $error("Thresholds not at range limits after reset.");
endmodule : ldu_thr_mem

//--- design/ldu_pulse_gen.sv
// Purpose: Cable test pulse generator, driving the 10 Mb or 100 Mb common driver.
// Assumes: The 100 Mb driver times the width code in 8 ns steps itself; this clock is too slow for that.
// Notes: A send in idle always starts the response monitor, even for a zero width; a send while busy is ignored.
`include "ldu_cfg.svh"
module ldu_pulse_gen
	import ldu_pkg::*;
(
	input  wire logic       clk,
	input  wire logic       rst_n,
	input  wire logic       send,
	input  wire logic       mode_100,
	input  wire logic       wide_10,
	input  wire logic [2:0] width,
	output logic            drive_pos,
	output logic            drive_neg,
	output logic [2:0]      width_code,
	output logic            monitor_start,
	output logic            busy
);
	ldu_pulse_state_t state;
	logic [1:0]       cnt;
	logic             neg_next;

	assign busy = (state != LDU_PG_IDLE);

	// Sequencer: fire for the pulse length, then one idle cycle before the next send.
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			state <= LDU_PG_IDLE;
			cnt <= 2'd0;
			monitor_start <= 1'b0;
		end else begin
			monitor_start <= 1'b0;
			unique case (state)
				LDU_PG_IDLE: begin
					if (send) begin
						monitor_start <= 1'b1;
						if (width != 3'd0) begin
							state <= LDU_PG_FIRE;
							cnt <= mode_100 ? 2'd0 : (wide_10 ? 2'(`LDU_LONG_CYC - 1) : 2'(`LDU_SHORT_CYC - 1));
						end
					end
				end
				LDU_PG_FIRE: begin
					if (cnt == 2'd0) begin
						state <= LDU_PG_DONE;
					end else begin
						cnt <= cnt - 2'd1;
					end
				end
				LDU_PG_DONE: state <= LDU_PG_IDLE;
				default: state <= LDU_PG_IDLE;
			endcase
		end
	end

	// Driver outputs; 100 Mb pulses swap sign each time, link pulses are always positive.
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			drive_pos <= 1'b0;
			drive_neg <= 1'b0;
			width_code <= 3'd0;
			neg_next <= 1'b0;
		end else if (state == LDU_PG_IDLE && send && width != 3'd0) begin
			drive_pos <= !(mode_100 && neg_next);
			drive_neg <= mode_100 && neg_next;
			width_code <= width;
			neg_next <= mode_100 ? !neg_next : neg_next;
		end else if (state == LDU_PG_FIRE && cnt == 2'd0) begin
			drive_pos <= 1'b0;
			drive_neg <= 1'b0;
		end
	end

	chk_zero_width: assert property (@(posedge clk) disable iff (!rst_n)
		(state == LDU_PG_IDLE && send && width == 3'd0) |=> (monitor_start && !drive_pos && !drive_neg && !busy))
		else $error("Zero width send drove a pulse or missed monitor start.");
	chk_alt_sign: assert property (@(posedge clk) disable iff (!rst_n)
		(state == LDU_PG_IDLE && send && width != 3'd0 && mode_100) |=>
		(drive_pos != $past(neg_next) && neg_next != $past(neg_next)))
		else $error("100 Mb pulse sign did not alternate.");
endmodule : ldu_pulse_gen

//--- testbench/ldu_phy_model.sv
// Purpose: Steady model of the PHY core and DSP feeding the diagnostics unit.
// Assumes: A linked, auto-negotiated 100 Mb port with crossed pairs and inverted polarity.
// Notes: Two bench inputs force 100 Mb without negotiation or drop the link; all else is fixed.
module ldu_phy_model
	import ldu_pkg::*;
(
	input  logic        forced_100,
	input  logic        link_down,
	output logic        link_valid,
	output logic        speed_100,
	output logic        an_mode,
	output logic        pol_inverted,
	output logic        mdix_active,
	output ldu_byte_t   cable_length_raw,
	output ldu_byte_t   freq_offset_raw,
	output ldu_byte_t   frequency_control_value,
	output ldu_byte_t   equalizer_coefficient,
	output ldu_byte_t   adaptive_gain_value,
	output ldu_byte_t   baseline_wander_value,
	output logic [15:0] error_square
);
	timeunit 1ns;
	timeprecision 1ns;
	// Values sit well inside every window, so only a moved threshold can warn.
	assign link_valid = !link_down;
	assign an_mode = !forced_100;
	assign {speed_100, pol_inverted, mdix_active} = 3'h7;
	assign {cable_length_raw, freq_offset_raw, frequency_control_value} = 24'h2A05F0;
	assign {equalizer_coefficient, adaptive_gain_value, baseline_wander_value} = 24'h104033;
	assign error_square = 16'h0001;
endmodule : ldu_phy_model

//--- testbench/ldu_diag_test.sv
// Purpose: Self-checking bench of the link diagnostics unit over its register port.
// Assumes: Read data is registered one cycle after the read strobe.
// Notes: Millisecond tick is shortened to 10 cycles so a run stays short.
module ldu_diag_test;
	import ldu_pkg::*;
	timeunit 1ns;
	timeprecision 1ns;
	logic clk = 0, rst_n = 0, reg_wr = 0, reg_rd = 0, clr = 0, ms = 0, dp = 0, dn = 0;
	logic forced_100 = 0, link_down = 0;
	logic [3:0] pw = '0;
	logic [4:0] reg_addr = '0;
	logic [15:0] reg_wdata = '0, reg_rdata, error_square;
	logic link_valid, speed_100, an_mode, pol_inverted, mdix_active, int_n, test_enable;
	logic tx_on_rx_pair, rx_on_rx_pair, drive_100, drive_pos, drive_neg, monitor_start;
	logic [2:0] width_code;
	ldu_byte_t cable_length_raw, freq_offset_raw, frequency_control_value;
	ldu_byte_t equalizer_coefficient, adaptive_gain_value, baseline_wander_value;
	int miscompares = 0, n_tests = 0;
	ldu_phy_model ldu_phy_model_inst (.forced_100, .link_down,
		.link_valid, .speed_100, .an_mode, .pol_inverted, .mdix_active,
		.cable_length_raw, .freq_offset_raw, .frequency_control_value, .equalizer_coefficient,
		.adaptive_gain_value, .baseline_wander_value, .error_square);
	ldu_diag #(.MS_CYCLES(10)) ldu_diag_inst (.clk, .rst_n, .reg_addr, .reg_wdata, .reg_wr, .reg_rd,
		.reg_rdata, .link_valid, .speed_100, .an_mode, .pol_inverted, .mdix_active, .cable_length_raw,
		.freq_offset_raw, .frequency_control_value, .equalizer_coefficient, .adaptive_gain_value,
		.baseline_wander_value, .error_square, .int_n, .test_enable, .tx_on_rx_pair, .rx_on_rx_pair,
		.drive_100, .drive_pos, .drive_neg, .width_code, .monitor_start);
	always #20 clk = ~clk;
	// Sticky capture and width count, since pulses are short and the bench checks later.
	// Reset clears them too, otherwise unknown outputs before reset would stick forever.
	always @(posedge clk) begin
		ms <= (clr || !rst_n) ? 1'b0 : ms | monitor_start;
		dp <= (clr || !rst_n) ? 1'b0 : dp | drive_pos;
		dn <= (clr || !rst_n) ? 1'b0 : dn | drive_neg;
		pw <= (clr || !rst_n) ? 4'h0 : pw + {3'b000, drive_pos};
	end
	task chk(input logic [15:0] s, input logic [15:0] e);
		n_tests++;
		if (s !== e) begin
			miscompares++;
			$display("MISMATCH %0t seen %h expected %h", $time, s, e);
		end
	endtask : chk
	task wr(input logic [4:0] a, input logic [15:0] d);
		@(posedge clk) {reg_addr, reg_wdata, reg_wr} <= {a, d, 1'b1};
		@(posedge clk) reg_wr <= 1'b0;
	endtask : wr
	task rd(input logic [4:0] a, input logic [15:0] e);
		@(posedge clk) {reg_addr, reg_rd} <= {a, 1'b1};
		@(posedge clk) reg_rd <= 1'b0;
		#1 chk(reg_rdata, e);
	endtask : rd
	// Clears the captures, sends one cable test write and lets the pulse finish.
	task fire(input logic [15:0] d);
		clr <= 1'b1;
		@(posedge clk) clr <= 1'b0;
		wr(5'h16, d);
		repeat (6) @(posedge clk);
		#1;
	endtask : fire
	task conclude;
		$display("compares %0d miscompares %0d", n_tests, miscompares);
		if (miscompares == 0 && n_tests > 0) begin
			$display("STATUS OK");
		end else begin
			$display("STATUS NOT OK");
		end
		$finish;
	endtask : conclude
	// Hang guard: the sequence needs well under 600 cycles.
	initial begin
		#40000 miscompares++;
		conclude();
	end
	initial begin
		repeat (12) @(posedge clk);
		rst_n <= 1'b1;
		rd(5'h14, 16'h0000);
		rd(5'h10, 16'h5001);
		rd(5'h1A, 16'h0010);
		wr(5'h13, 16'h0002);
		rd(5'h14, 16'h002A);
		rd(5'h15, 16'h0005);
		wr(5'h15, 16'h0100);
		rd(5'h15, 16'h01F0);
		wr(5'h1E, 16'h0300);
		rd(5'h1E, 16'h03FF);
		wr(5'h1E, 16'h2400);
		rd(5'h1E, 16'h2433);
		wr(5'h11, 16'h0003);
		wr(5'h12, 16'h0080);
		wr(5'h1E, 16'h1340);
		wr(5'h1D, 16'h8000);
		repeat (4) @(posedge clk);
		rd(5'h1D, 16'h8000);
		chk(int_n, 1'b1);
		wr(5'h1E, 16'h133F);
		repeat (4) @(posedge clk);
		#1 chk(int_n, 1'b0);
		rd(5'h1D, 16'h8008);
		wr(5'h1E, 16'h13FF);
		rd(5'h1E, 16'h03FF);
		rd(5'h1D, 16'h8008);
		rd(5'h1D, 16'h8000);
		rd(5'h12, 16'h8080);
		rd(5'h12, 16'h0080);
		chk(int_n, 1'b1);
		fire(16'hC800);
		chk({ms, dp, dn}, 3'b100);
		fire(16'hCB00);
		chk({ms, dp, drive_100, width_code}, 6'h3B);
		chk(pw, 4'd1);
		fire(16'hDB00);
		chk({dp, dn, tx_on_rx_pair, rx_on_rx_pair}, 4'b0101);
		fire(16'hAB40);
		chk({test_enable, drive_100, tx_on_rx_pair, rx_on_rx_pair}, 4'hA);
		chk(pw, 4'd3);
		wr(5'h1A, 16'h0006);
		repeat (100) @(posedge clk);
		rd(5'h1A, 16'h8006);
		rd(5'h1B, 16'h0050);
		rd(5'h1B, 16'h0000);
		@(posedge clk) forced_100 <= 1'b1;
		rd(5'h10, 16'h4001);
		@(posedge clk) link_down <= 1'b1;
		rd(5'h14, 16'h0000);
		rd(5'h15, 16'h0000);
		conclude();
	end
endmodule : ldu_diag_test
